// >>> design/hspd_map.svh
// Purpose: register codes, reset values and timing figures of the serial packetizer
// Assumes: register codes equal the binary command codes of the device
// Notes: definitions only
`ifndef HSPD_MAP_SVH
`define HSPD_MAP_SVH

// ****************************************
// register codes
// ****************************************
`define HSPD_A_FAULT_TALLY    8'h0f
`define HSPD_A_DEFAULT_LOAD   8'h0e
`define HSPD_A_LINE_TWO       8'h16
`define HSPD_A_STRENGTH       8'h1c
`define HSPD_A_THRESHOLD      8'h20
`define HSPD_A_TIMEOUT        8'h21
`define HSPD_A_PWM_HOLD       8'h22
`define HSPD_A_SERIAL_UPPER   8'h25
`define HSPD_A_SERIAL_LOWER   8'h26
`define HSPD_A_MAX_PACKET     8'h29
`define HSPD_A_BUF_SIZE       8'h2c
`define HSPD_A_PARITY         8'h30
`define HSPD_A_GOOD_TALLY     8'h31

// ****************************************
// reset values and ranges
// ****************************************
`define HSPD_RST_PARITY       3'h0
`define HSPD_MAX_PARITY       3'h5
`define HSPD_RST_MAX_PACKET   16'h0040
`define HSPD_MIN_MAX_PACKET   16'h0002
`define HSPD_TOP_MAX_PACKET   16'h0100
`define HSPD_RST_THRESHOLD    16'h0001
`define HSPD_RST_TIMEOUT      16'h0000
`define HSPD_RST_LINE_TWO     2'h0
`define HSPD_MAX_LINE_TWO     2'h2
`define HSPD_RST_PWM_HOLD     8'h00
`define HSPD_HOLD_FOREVER     8'hff
`define HSPD_TALLY_MAX        16'hffff
`define HSPD_FLOW_HYST        16'h0010

// ****************************************
// strength and pwm figures
// ****************************************
`define HSPD_STRENGTH_FLOOR   8'h06
`define HSPD_PWM_STEPS        6'h28
`define HSPD_PWM_MAX_STEP     6'h26
`define HSPD_PWM_BASE_STEP    8'h0d

// ****************************************
// timing figures
// ****************************************
`define HSPD_CLK_MHZ          100
`define HSPD_TICK_US          200
`define HSPD_PWM_STEP_US      208
`define HSPD_HOLD_UNIT_US     100000
`define HSPD_BIT_TIME_NS      104167
`define HSPD_CLK_NS           10

`endif

// >>> design/hspd_pkg.sv
// Purpose: types of the serial packetizer
// Assumes: hspd_map.svh holds the map figures; buffer depth, flow threshold and serial numbers are hspd_top parameters
// Notes: none
package hspd_pkg;

  typedef enum logic [2:0] {
    HSPD_FMT_NONE,
    HSPD_FMT_EVEN,
    HSPD_FMT_ODD,
    HSPD_FMT_MARK,
    HSPD_FMT_SPACE,
    HSPD_FMT_NINE
  } hspd_fmt_e;

  typedef enum logic [2:0] {
    HSPD_RX_IDLE,
    HSPD_RX_START,
    HSPD_RX_DATA,
    HSPD_RX_PAR,
    HSPD_RX_STOP
  } hspd_rx_e;

  typedef enum logic {
    HSPD_PZ_COLLECT,
    HSPD_PZ_SEND
  } hspd_pz_e;

endpackage

// >>> design/hspd_top.sv
// Purpose: host serial receiver, packetizer, diagnostics and strength pwm
// Assumes: rf side logic runs on clk; host line and config pin are asynchronous
// Notes: registers reached by command code on the command port
`timescale 1ns/1ns
`include "hspd_map.svh"

module hspd_top
  import hspd_pkg::*;
#(
  parameter int DI_DEPTH = 255,
  parameter int FLOW_THRESHOLD = DI_DEPTH - 17,
  parameter int BIT_CYC = `HSPD_BIT_TIME_NS / `HSPD_CLK_NS,
  parameter int TICK_CYC = `HSPD_TICK_US * `HSPD_CLK_MHZ,
  parameter int PWM_STEP_CYC = `HSPD_PWM_STEP_US * `HSPD_CLK_MHZ,
  parameter int HOLD_UNIT_CYC = `HSPD_HOLD_UNIT_US * `HSPD_CLK_MHZ,
  parameter logic [15:0] SERIAL_UPPER = 16'h1234,
  parameter logic [15:0] SERIAL_LOWER = 16'h5678
)
(
  input wire logic clk,
  input wire logic rst_n,
  input wire logic host_rx,
  output logic cts_n,
  output logic [1:0] input_line_two,
  input wire logic cfg_pin_in,
  output logic cfg_pin_out,
  output logic cfg_pin_oe_n,
  output logic cmd_mode_req,
  input wire logic cmd_valid,
  input wire logic cmd_write,
  input wire logic [7:0] cmd_code,
  input wire logic [15:0] cmd_wdata,
  output logic rsp_valid,
  output logic rsp_err,
  output logic [15:0] rsp_data,
  output logic rf_valid,
  output logic [8:0] rf_data,
  output logic rf_last,
  input wire logic rf_ready,
  input wire logic rx_pkt_good,
  input wire logic rx_pkt_fault,
  input wire logic [7:0] rx_pkt_strength
);

  // arbitrary serial number values; output buffer depth derived
  localparam int DO_DEPTH = (DI_DEPTH * 3) / 2;
  localparam int CW = $clog2(DI_DEPTH + 1);
  localparam int AW = $clog2(DI_DEPTH);

  // ****************************************
  // reset and input synchronisers
  // ****************************************
  logic rst_a_ff, rst_b_ff, rst_s_n;
  logic rx_a_ff, rx_b_ff, cfg_a_ff, cfg_b_ff;

  always_ff @(posedge clk or negedge rst_n)
  begin
    if (!rst_n)
    begin
      rst_a_ff <= 1'b0;
      rst_b_ff <= 1'b0;
    end
    else
    begin
      rst_a_ff <= 1'b1;
      rst_b_ff <= rst_a_ff;
    end
  end
  assign rst_s_n = rst_b_ff;

  always_ff @(posedge clk or negedge rst_s_n)
  begin
    if (!rst_s_n)
    begin
      rx_a_ff <= 1'b1;
      rx_b_ff <= 1'b1;
      cfg_a_ff <= 1'b1;
      cfg_b_ff <= 1'b1;
    end
    else
    begin
      rx_a_ff <= host_rx;
      rx_b_ff <= rx_a_ff;
      cfg_a_ff <= cfg_pin_in;
      cfg_b_ff <= cfg_a_ff;
    end
  end

  // ****************************************
  // configuration registers
  // ****************************************
  logic [2:0] parity_select_ff;
  logic [15:0] max_packet_size_ff, packetization_threshold_ff, packetization_timeout_ff;
  logic [1:0] input_line_two_function_ff;
  logic [7:0] strength_pwm_hold_time_ff, last_packet_strength_ff;
  logic wr;
  assign wr = cmd_valid && cmd_write;

  always_ff @(posedge clk or negedge rst_s_n)
  begin
    if (!rst_s_n)
    begin
      parity_select_ff <= `HSPD_RST_PARITY;
      max_packet_size_ff <= `HSPD_RST_MAX_PACKET;
      packetization_threshold_ff <= `HSPD_RST_THRESHOLD;
      packetization_timeout_ff <= `HSPD_RST_TIMEOUT;
      input_line_two_function_ff <= `HSPD_RST_LINE_TWO;
      strength_pwm_hold_time_ff <= `HSPD_RST_PWM_HOLD;
    end
    else if (wr && cmd_code == `HSPD_A_DEFAULT_LOAD)
    begin
      parity_select_ff <= `HSPD_RST_PARITY;
      max_packet_size_ff <= `HSPD_RST_MAX_PACKET;
      packetization_threshold_ff <= `HSPD_RST_THRESHOLD;
      packetization_timeout_ff <= `HSPD_RST_TIMEOUT;
      input_line_two_function_ff <= `HSPD_RST_LINE_TWO;
      strength_pwm_hold_time_ff <= `HSPD_RST_PWM_HOLD;
    end
    else if (wr)
    begin
      if (cmd_code == `HSPD_A_PARITY && cmd_wdata[15:0] <= {13'h0000, `HSPD_MAX_PARITY})
        parity_select_ff <= cmd_wdata[2:0];
      if (cmd_code == `HSPD_A_MAX_PACKET && cmd_wdata >= `HSPD_MIN_MAX_PACKET
          && cmd_wdata <= `HSPD_TOP_MAX_PACKET)
      begin
        max_packet_size_ff <= cmd_wdata;
        if (cmd_wdata < packetization_threshold_ff)
          packetization_threshold_ff <= cmd_wdata;
      end
      if (cmd_code == `HSPD_A_THRESHOLD && cmd_wdata != 16'h0000
          && cmd_wdata <= max_packet_size_ff)
        packetization_threshold_ff <= cmd_wdata;
      if (cmd_code == `HSPD_A_TIMEOUT)
        packetization_timeout_ff <= cmd_wdata;
      if (cmd_code == `HSPD_A_LINE_TWO && cmd_wdata <= {14'h0000, `HSPD_MAX_LINE_TWO})
        input_line_two_function_ff <= cmd_wdata[1:0];
      if (cmd_code == `HSPD_A_PWM_HOLD && cmd_wdata[15:8] == 8'h00)
        strength_pwm_hold_time_ff <= cmd_wdata[7:0];
    end
  end

  // ****************************************
  // uart receiver
  // ****************************************
  hspd_rx_e rx_state_ff;
  logic [15:0] bit_cnt_ff;
  logic [3:0] bit_idx_ff;
  logic [8:0] shift_ff;
  logic par_bad_ff, byte_ok_ff, silence_rst;
  logic [8:0] byte_data_ff;
  logic bit_mid, bit_end, last_data_bit, par_want;
  hspd_fmt_e fmt;

  assign fmt = hspd_fmt_e'(parity_select_ff);
  assign bit_end = (bit_cnt_ff == 16'(BIT_CYC - 1));
  assign bit_mid = (bit_cnt_ff == 16'(BIT_CYC / 2));
  assign last_data_bit = (bit_idx_ff == ((fmt == HSPD_FMT_NINE) ? 4'h8 : 4'h7));

  always_comb
  begin
    unique case (fmt)
      HSPD_FMT_EVEN: par_want = ^shift_ff[7:0];
      HSPD_FMT_ODD: par_want = ~^shift_ff[7:0];
      HSPD_FMT_MARK: par_want = 1'b1;
      default: par_want = 1'b0;
    endcase
  end

  always_ff @(posedge clk or negedge rst_s_n)
  begin
    if (!rst_s_n)
    begin
      rx_state_ff <= HSPD_RX_IDLE;
      bit_cnt_ff <= 16'h0000;
      bit_idx_ff <= 4'h0;
      shift_ff <= 9'h000;
      par_bad_ff <= 1'b0;
      byte_ok_ff <= 1'b0;
      byte_data_ff <= 9'h000;
    end
    else
    begin
      byte_ok_ff <= 1'b0;
      bit_cnt_ff <= (rx_state_ff == HSPD_RX_IDLE || bit_end) ? 16'h0000 : bit_cnt_ff + 16'h0001;
      unique case (rx_state_ff)
        HSPD_RX_IDLE:
          if (!rx_b_ff)
            rx_state_ff <= HSPD_RX_START;
        HSPD_RX_START:
          if (bit_mid && rx_b_ff)
            rx_state_ff <= HSPD_RX_IDLE;
          else if (bit_end)
          begin
            rx_state_ff <= HSPD_RX_DATA;
            bit_idx_ff <= 4'h0;
            par_bad_ff <= 1'b0;
            shift_ff <= 9'h000;
          end
        HSPD_RX_DATA:
        begin
          if (bit_mid)
            shift_ff[bit_idx_ff] <= rx_b_ff;
          if (bit_end)
          begin
            bit_idx_ff <= bit_idx_ff + 4'h1;
            if (last_data_bit)
              rx_state_ff <= (fmt == HSPD_FMT_NONE || fmt == HSPD_FMT_NINE)
                             ? HSPD_RX_STOP : HSPD_RX_PAR;
          end
        end
        HSPD_RX_PAR:
        begin
          if (bit_mid)
            par_bad_ff <= (rx_b_ff != par_want);
          if (bit_end)
            rx_state_ff <= HSPD_RX_STOP;
        end
        HSPD_RX_STOP:
          if (bit_mid)
          begin
            rx_state_ff <= HSPD_RX_IDLE;
            byte_ok_ff <= rx_b_ff && !par_bad_ff;
            byte_data_ff <= shift_ff;
          end
      endcase
    end
  end

  // ****************************************
  // input buffer and packetizer
  // ****************************************
  logic [8:0] buf_mem [DI_DEPTH];
  logic [AW-1:0] wr_ptr_ff, rd_ptr_ff;
  logic [CW-1:0] count_ff;
  logic [15:0] sent_ff, silence_ff, tick_cnt_ff;
  logic tick, push, pop, pop_last, trig;
  hspd_pz_e pz_state_ff;

  assign push = byte_ok_ff && (count_ff != CW'(DI_DEPTH));
  assign pop = (pz_state_ff == HSPD_PZ_SEND) && (count_ff != '0) && (!rf_valid || rf_ready);
  assign pop_last = (sent_ff + 16'h0001 == max_packet_size_ff)
                    || (count_ff == CW'(1) && !push);
  assign silence_rst = byte_ok_ff;
  assign tick = (tick_cnt_ff == 16'(TICK_CYC - 1));
  assign trig = (count_ff != '0) && ((16'(count_ff) >= packetization_threshold_ff)
                || (packetization_timeout_ff != 16'h0000
                    && silence_ff >= packetization_timeout_ff));

  always_ff @(posedge clk)
  begin
    if (push)
      buf_mem[wr_ptr_ff] <= byte_data_ff;
  end

  always_ff @(posedge clk or negedge rst_s_n)
  begin
    if (!rst_s_n)
    begin
      tick_cnt_ff <= 16'h0000;
      silence_ff <= 16'h0000;
    end
    else
    begin
      tick_cnt_ff <= (tick || silence_rst) ? 16'h0000 : tick_cnt_ff + 16'h0001;
      if (silence_rst)
        silence_ff <= 16'h0000;
      else if (tick && silence_ff != 16'hffff)
        silence_ff <= silence_ff + 16'h0001;
    end
  end

  always_ff @(posedge clk or negedge rst_s_n)
  begin
    if (!rst_s_n)
    begin
      wr_ptr_ff <= '0;
      rd_ptr_ff <= '0;
      count_ff <= '0;
      pz_state_ff <= HSPD_PZ_COLLECT;
      sent_ff <= 16'h0000;
      rf_valid <= 1'b0;
      rf_data <= 9'h000;
      rf_last <= 1'b0;
    end
    else
    begin
      if (push)
        wr_ptr_ff <= (wr_ptr_ff == AW'(DI_DEPTH - 1)) ? '0 : wr_ptr_ff + AW'(1);
      if (pop)
        rd_ptr_ff <= (rd_ptr_ff == AW'(DI_DEPTH - 1)) ? '0 : rd_ptr_ff + AW'(1);
      count_ff <= count_ff + CW'(push) - CW'(pop);
      if (rf_valid && rf_ready && !pop)
        rf_valid <= 1'b0;
      if (pop)
      begin
        rf_valid <= 1'b1;
        rf_data <= buf_mem[rd_ptr_ff];
        rf_last <= pop_last;
        sent_ff <= pop_last ? 16'h0000 : sent_ff + 16'h0001;
      end
      unique case (pz_state_ff)
        HSPD_PZ_COLLECT:
          if (trig)
            pz_state_ff <= HSPD_PZ_SEND;
        HSPD_PZ_SEND:
          if (pop && pop_last && count_ff == CW'(1) && !push)
            pz_state_ff <= HSPD_PZ_COLLECT;
      endcase
    end
  end

  // ****************************************
  // flow control and line two
  // ****************************************
  always_ff @(posedge clk or negedge rst_s_n)
  begin
    if (!rst_s_n)
    begin
      cts_n <= 1'b0;
      input_line_two <= `HSPD_RST_LINE_TWO;
    end
    else
    begin
      input_line_two <= input_line_two_function_ff;
      if (16'(count_ff) >= 16'(FLOW_THRESHOLD))
        cts_n <= 1'b1;
      else if (16'(count_ff) + `HSPD_FLOW_HYST < 16'(FLOW_THRESHOLD))
        cts_n <= 1'b0;
    end
  end

  // ****************************************
  // receive tallies and strength
  // ****************************************
  logic [15:0] rx_fault_tally_ff, rx_good_tally_ff, fault_base, good_base;

  assign fault_base = (wr && cmd_code == `HSPD_A_FAULT_TALLY) ? cmd_wdata : rx_fault_tally_ff;
  assign good_base = (wr && cmd_code == `HSPD_A_GOOD_TALLY) ? cmd_wdata : rx_good_tally_ff;

  always_ff @(posedge clk or negedge rst_s_n)
  begin
    if (!rst_s_n)
    begin
      rx_fault_tally_ff <= 16'h0000;
      rx_good_tally_ff <= 16'h0000;
      last_packet_strength_ff <= `HSPD_STRENGTH_FLOOR;
    end
    else
    begin
      // a load in the same cycle as an event still counts the event
      rx_fault_tally_ff <= (rx_pkt_fault && fault_base != `HSPD_TALLY_MAX)
                           ? fault_base + 16'h0001 : fault_base;
      rx_good_tally_ff <= (rx_pkt_good && good_base != `HSPD_TALLY_MAX)
                          ? good_base + 16'h0001 : good_base;
      if (rx_pkt_good)
        last_packet_strength_ff <= rx_pkt_strength;
    end
  end

  // ****************************************
  // command answers
  // ****************************************
  always_ff @(posedge clk or negedge rst_s_n)
  begin
    if (!rst_s_n)
    begin
      rsp_valid <= 1'b0;
      rsp_err <= 1'b0;
      rsp_data <= 16'h0000;
    end
    else
    begin
      rsp_valid <= cmd_valid;
      rsp_err <= 1'b0;
      rsp_data <= 16'h0000;
      if (cmd_valid)
        unique case (cmd_code)
          `HSPD_A_FAULT_TALLY: rsp_data <= rx_fault_tally_ff;
          `HSPD_A_GOOD_TALLY: rsp_data <= rx_good_tally_ff;
          `HSPD_A_DEFAULT_LOAD: rsp_data <= 16'h0000;
          `HSPD_A_LINE_TWO: rsp_data <= {14'h0000, input_line_two_function_ff};
          `HSPD_A_STRENGTH: rsp_data <= {8'h00, last_packet_strength_ff};
          `HSPD_A_THRESHOLD: rsp_data <= packetization_threshold_ff;
          `HSPD_A_TIMEOUT: rsp_data <= packetization_timeout_ff;
          `HSPD_A_PWM_HOLD: rsp_data <= {8'h00, strength_pwm_hold_time_ff};
          `HSPD_A_SERIAL_UPPER: rsp_data <= SERIAL_UPPER;
          `HSPD_A_SERIAL_LOWER: rsp_data <= SERIAL_LOWER;
          `HSPD_A_MAX_PACKET: rsp_data <= max_packet_size_ff;
          `HSPD_A_BUF_SIZE: rsp_data <= {8'h00, 8'(DI_DEPTH)};
          `HSPD_A_PARITY: rsp_data <= {13'h0000, parity_select_ff};
          default: rsp_err <= 1'b1;
        endcase
    end
  end

  // ****************************************
  // strength pwm on the config pin
  // ****************************************
  logic [15:0] step_cnt_ff;
  logic [5:0] phase_ff, duty_ff;
  logic [31:0] hold_cnt_ff;
  logic [7:0] hold_units_ff;
  logic [1:0] strap_wait_ff;
  logic seen_pkt_ff, showing_ff, step_tick;
  logic [7:0] above, duty_calc;

  assign step_tick = (step_cnt_ff == 16'(PWM_STEP_CYC - 1));
  assign above = (rx_pkt_strength > `HSPD_STRENGTH_FLOOR)
                 ? rx_pkt_strength - `HSPD_STRENGTH_FLOOR : 8'h00;
  // 0.6 step per dB above base of 13 steps, capped at 38 of 40
  assign duty_calc = `HSPD_PWM_BASE_STEP + 8'((16'(above) * 16'd3) / 16'd5);

  always_ff @(posedge clk or negedge rst_s_n)
  begin
    if (!rst_s_n)
    begin
      strap_wait_ff <= 2'h0;
      cmd_mode_req <= 1'b0;
      cfg_pin_oe_n <= 1'b1;
      cfg_pin_out <= 1'b0;
      step_cnt_ff <= 16'h0000;
      phase_ff <= 6'h00;
      duty_ff <= 6'h00;
      hold_cnt_ff <= 32'h0000_0000;
      hold_units_ff <= 8'h00;
      seen_pkt_ff <= 1'b0;
      showing_ff <= 1'b0;
    end
    else
    begin
      if (strap_wait_ff != 2'h3)
      begin
        strap_wait_ff <= strap_wait_ff + 2'h1;
        if (strap_wait_ff == 2'h2)
          cmd_mode_req <= !cfg_b_ff;
      end
      else
        cfg_pin_oe_n <= (strength_pwm_hold_time_ff == 8'h00);
      step_cnt_ff <= step_tick ? 16'h0000 : step_cnt_ff + 16'h0001;
      if (step_tick)
        phase_ff <= (phase_ff == `HSPD_PWM_STEPS - 6'h01) ? 6'h00 : phase_ff + 6'h01;
      if (rx_pkt_good)
      begin
        seen_pkt_ff <= 1'b1;
        showing_ff <= 1'b1;
        hold_cnt_ff <= 32'h0000_0000;
        hold_units_ff <= 8'h00;
        if (above == 8'h00)
          duty_ff <= 6'h00;
        else if (duty_calc > {2'h0, `HSPD_PWM_MAX_STEP})
          duty_ff <= `HSPD_PWM_MAX_STEP;
        else
          duty_ff <= duty_calc[5:0];
      end
      else if (showing_ff && strength_pwm_hold_time_ff != `HSPD_HOLD_FOREVER)
      begin
        hold_cnt_ff <= (hold_cnt_ff == 32'(HOLD_UNIT_CYC - 1))
                       ? 32'h0000_0000 : hold_cnt_ff + 32'h0000_0001;
        if (hold_cnt_ff == 32'(HOLD_UNIT_CYC - 1))
        begin
          hold_units_ff <= hold_units_ff + 8'h01;
          if (hold_units_ff + 8'h01 >= strength_pwm_hold_time_ff)
            showing_ff <= 1'b0;
        end
      end
      cfg_pin_out <= (strap_wait_ff == 2'h3) && (strength_pwm_hold_time_ff != 8'h00)
                     && seen_pkt_ff && showing_ff && (phase_ff < duty_ff);
    end
  end

endmodule

// >>> sim/host_serial_packetizer_diag_tb.sv
// Purpose: self-checking bench of the serial packetizer
// Assumes: shortened timing parameters
// Notes: rf side and packet events driven by the bench
`timescale 1ns/1ns
module host_serial_packetizer_diag_tb;
  logic clk, rst_n, host_rx, cts_n, cfg_pin_out, cfg_pin_oe_n, cmd_valid, cmd_write;
  logic rsp_valid, rsp_err, rf_valid, rf_last, rf_ready, rx_pkt_good, rx_pkt_fault, hold_rf;
  logic cfg_pin_in, cmd_mode_req;
  logic [1:0] input_line_two;
  logic [7:0] cmd_code, rx_pkt_strength;
  logic [15:0] cmd_wdata, rsp_data, r;
  logic [8:0] rf_data;
  logic [17:0] e;
  logic [17:0] rq[$];
  logic [9:0] fq[$];
  int n_fail, n_compared, hi;
  logic [7:0] rc[13] = '{8'h30, 8'h29, 8'h20, 8'h21, 8'h16, 8'h22, 8'h0f, 8'h31, 8'h1c, 8'h25,
    8'h26, 8'h2c, 8'h77};
  logic [15:0] re[13] = '{0, 16'h0040, 16'h0001, 0, 0, 0, 0, 0, 16'h0006, 16'h1234, 16'h5678,
    16'h00ff, 0};
  hspd_top #(.BIT_CYC(16), .TICK_CYC(20), .PWM_STEP_CYC(4), .HOLD_UNIT_CYC(50)) dut (
    .clk, .rst_n, .host_rx, .cts_n, .input_line_two, .cfg_pin_in, .cfg_pin_out,
    .cfg_pin_oe_n, .cmd_mode_req, .cmd_valid, .cmd_write, .cmd_code, .cmd_wdata,
    .rsp_valid, .rsp_err, .rsp_data, .rf_valid, .rf_data, .rf_last, .rf_ready,
    .rx_pkt_good, .rx_pkt_fault, .rx_pkt_strength);
  hspd_host_uart #(.BIT_CYC(16)) host (.clk, .host_rx);
  initial
  begin
    clk = 0;
    forever #5 clk = ~clk;
  end
  always @(posedge clk) rf_ready <= #1 !hold_rf && $urandom_range(0, 1);
  // ****************************************
  // shared tasks
  // ****************************************
  task automatic chk(input logic [31:0] x, input logic [31:0] g);
    n_compared++;
    if (g !== x)
    begin
      n_fail++;
      $display("BAD t=%0t exp=%h got=%h", $time, x, g);
    end
  endtask
  task automatic cmd(input logic w, input logic [7:0] c, input logic [15:0] d);
    rq.push_back({!w, c == 8'h77, w ? 16'h0 : d});
    cmd_valid = 1;
    cmd_write = w;
    cmd_code = c;
    cmd_wdata = d;
    @(posedge clk) #1;
    cmd_valid = 0;
    @(posedge clk) #1;
  endtask
  task automatic pkt(input logic g, input logic [7:0] s);
    rx_pkt_good = g;
    rx_pkt_fault = !g;
    rx_pkt_strength = s;
    @(posedge clk) #1;
    rx_pkt_good = 0;
    rx_pkt_fault = 0;
    @(posedge clk) #1;
  endtask
  task automatic do_reset;
    rst_n = 0;
    repeat (8) @(posedge clk);
    #1 rst_n = 1;
    repeat (3) @(posedge clk);
    #1;
  endtask
  task automatic finish_test;
    $display("compared %0d mismatches %0d", n_compared, n_fail);
    if (n_fail == 0 && n_compared > 0)
      $display("bench passed");
    else
      $display("bench failed");
    $finish;
  endtask
  always @(posedge clk)
  begin
    if (rsp_valid)
    begin
      e = rq.size() ? rq.pop_front() : 'x;
      chk({e[16], e[17] ? e[15:0] : rsp_data}, {rsp_err, rsp_data});
    end
    if (rf_valid && rf_ready)
      chk(fq.size() ? fq.pop_front() : 'x, {rf_last, rf_data});
  end
  initial
  begin
    #800_000;
    n_fail++;
    finish_test;
  end
  initial
  begin
    void'($urandom(32'hf27f));
    {cmd_valid, cmd_write, cmd_code, cmd_wdata, hold_rf, rf_ready} = 0;
    {rx_pkt_good, rx_pkt_fault, rx_pkt_strength} = 0;
    cfg_pin_in = 1;
    do_reset;
    foreach (rc[i]) cmd(0, rc[i], re[i]);
    chk(0, cts_n);
    chk(0, cmd_mode_req);
    cmd(1, 8'h20, 16'h0030);
    cmd(1, 8'h29, 16'h0010);
    cmd(0, 8'h20, 16'h0010);
    cmd(1, 8'h29, 16'h0001);
    cmd(1, 8'h29, 16'h0101);
    cmd(0, 8'h29, 16'h0010);
    for (int i = 0; i < 4; i++)
    begin
      cmd(1, 8'h16, 16'(i));
      chk(i < 3 ? i : 2, input_line_two);
    end
    cmd(1, 8'h0f, 16'hfffe);
    pkt(0, 0);
    pkt(0, 0);
    cmd(0, 8'h0f, 16'hffff);
    r = 16'($urandom_range(0, 65534));
    cmd(1, 8'h31, r);
    pkt(1, 8'h1a);
    cmd(0, 8'h31, r + 16'h0001);
    cmd(0, 8'h1c, 16'h001a);
    cmd(1, 8'h30, 16'h0003);
    cmd(1, 8'h0e, 0);
    cmd(0, 8'h30, 0);
    cmd(0, 8'h16, 0);
    for (int m = 0; m < 6; m++)
    begin
      r = 16'($urandom);
      cmd(1, 8'h30, 16'(m));
      fq.push_back({1'b1, m == 5 ? r[8] : 1'b0, r[7:0]});
      host.send(r[8:0], m[2:0], 0);
      if (m inside {[1:4]})
        host.send(~r[8:0], m[2:0], 1);
    end
    cmd(1, 8'h30, 0);
    cmd(1, 8'h20, 16'h0003);
    cmd(1, 8'h29, 16'h0002);
    hold_rf = 1;
    for (int k = 0; k < 3; k++)
    begin
      r = 16'($urandom);
      fq.push_back({k != 0, 1'b0, r[7:0]});
      host.send({1'b0, r[7:0]}, 0, 0);
    end
    hold_rf = 0;
    wait (fq.size() == 0);
    @(posedge clk) #1;
    cmd(1, 8'h29, 16'h0040);
    r = 16'($urandom);
    host.send({1'b0, r[7:0]}, 0, 0);
    repeat (300) @(posedge clk);
    #1;
    fq.push_back({2'b00, r[7:0]});
    fq.push_back({2'b10, r[15:8]});
    host.send({1'b0, r[15:8]}, 0, 0);
    cmd(1, 8'h21, 16'h0003);
    fq.push_back({2'b10, r[7:0]});
    host.send({1'b0, r[7:0]}, 0, 0);
    repeat (25) @(posedge clk);
    chk(1, fq.size());
    repeat (100) @(posedge clk);
    chk(0, fq.size());
    cmd(1, 8'h22, 16'h00ff);
    for (int k = 0; k < 3; k++)
    begin
      pkt(1, 8'(16 + 10 * k));
      repeat (200) @(posedge clk);
      hi = 0;
      repeat (160)
      begin
        @(posedge clk);
        hi += cfg_pin_out;
      end
      chk(160 * (475 + 150 * k) / 1000, hi);
    end
    cmd(1, 8'h22, 16'h0002);
    pkt(1, 8'h1a);
    repeat (300) @(posedge clk);
    hi = 0;
    repeat (160)
    begin
      @(posedge clk);
      hi += cfg_pin_out;
    end
    chk(0, hi);
    cfg_pin_in = 0;
    do_reset;
    cmd(0, 8'h0f, 0);
    cmd(0, 8'h22, 0);
    chk(1, cmd_mode_req);
    chk(1, cfg_pin_oe_n);
    repeat (4) @(posedge clk);
    finish_test;
  end
endmodule
bind hspd_top hspd_monitor #(.DI_DEPTH(DI_DEPTH), .SERIAL_UPPER(SERIAL_UPPER),
  .SERIAL_LOWER(SERIAL_LOWER)) mon (.clk, .rst_n, .input_line_two, .cfg_pin_out,
  .cfg_pin_oe_n, .cmd_valid, .cmd_write, .cmd_code, .rsp_valid, .rsp_err, .rsp_data,
  .rf_valid, .rf_data, .rf_last, .rf_ready);

// >>> sim/hspd_host_uart.sv
// Purpose: host uart sender model
// Assumes: idle high line, lsb first
// Notes: bad flips the parity bit
`timescale 1ns/1ns
module hspd_host_uart #(
  parameter int BIT_CYC = 16
)
(
  input wire logic clk,
  output logic host_rx
);
  initial host_rx = 1'b1;
  task automatic bit_out(input logic v);
    host_rx = v;
    repeat (BIT_CYC) @(posedge clk);
    #1;
  endtask
  task automatic send(input logic [8:0] d, input logic [2:0] fmt, input logic bad);
    logic p;
    p = (fmt == 3'h1) ? ^d[7:0] : (fmt == 3'h2) ? ~^d[7:0] : (fmt == 3'h3);
    bit_out(1'b0);
    for (int i = 0; i < ((fmt == 3'h5) ? 9 : 8); i++)
      bit_out(d[i]);
    if (fmt inside {[3'h1:3'h4]})
      bit_out(p ^ bad);
    bit_out(1'b1);
  endtask
endmodule

// >>> sim/hspd_monitor.sv
// Purpose: port assertions of the serial packetizer
// Assumes: bound to hspd_top from the bench top file
// Notes: single clock domain
`timescale 1ns/1ns
module hspd_monitor #(
  parameter int DI_DEPTH = 255,
  parameter logic [15:0] SERIAL_UPPER = 16'h1234,
  parameter logic [15:0] SERIAL_LOWER = 16'h5678
)
(
  input wire logic clk,
  input wire logic rst_n,
  input wire logic [1:0] input_line_two,
  input wire logic cfg_pin_out,
  input wire logic cfg_pin_oe_n,
  input wire logic cmd_valid,
  input wire logic cmd_write,
  input wire logic [7:0] cmd_code,
  input wire logic rsp_valid,
  input wire logic rsp_err,
  input wire logic [15:0] rsp_data,
  input wire logic rf_valid,
  input wire logic [8:0] rf_data,
  input wire logic rf_last,
  input wire logic rf_ready
);
  // ****************************************
  // bytes already sent in current packet
  // ****************************************
  logic [8:0] pkt_cnt_ff;
  logic rd;
  assign rd = cmd_valid && !cmd_write;
  always_ff @(posedge clk or negedge rst_n)
    if (!rst_n)
      pkt_cnt_ff <= 9'h000;
    else if (rf_valid && rf_ready)
      pkt_cnt_ff <= rf_last ? 9'h000 : pkt_cnt_ff + 9'h001;
  default clocking @(posedge clk); endclocking
  default disable iff (!rst_n);
  line_two_range_a: assert property (input_line_two != 2'h3)
    else $error("line two field out of range");
  pwm_drive_a: assert property (cfg_pin_out |-> !cfg_pin_oe_n)
    else $error("pwm high on undriven pin");
  rf_hold_a: assert property (rf_valid && !rf_ready |=>
    rf_valid && $stable({rf_data, rf_last}))
    else $error("rf byte changed before taken");
  burst_follow_a: assert property (rf_valid && rf_ready && !rf_last |=> rf_valid)
    else $error("gap inside packet");
  pkt_limit_a: assert property (rf_valid |-> pkt_cnt_ff < 9'h100)
    else $error("packet longer than limit");
  serial_read_a: assert property (rd && cmd_code inside {8'h25, 8'h26} |=>
    rsp_valid && rsp_data == ($past(cmd_code) == 8'h25 ? SERIAL_UPPER : SERIAL_LOWER))
    else $error("serial word wrong");
  buf_size_a: assert property (rd && cmd_code == 8'h2c |=> rsp_data == 16'(DI_DEPTH))
    else $error("buffer size readout wrong");
  strength_rng_a: assert property (rd && cmd_code == 8'h1c |=> rsp_data inside {[6:54]})
    else $error("strength readout out of range");
  cover property (rf_valid && rf_ready && rf_last);
  cover property (rsp_valid && rsp_err);
  cover property (cfg_pin_out);
endmodule
